/* File: swa_defs.svh */
// Purpose: Named constants for the signed word adder
// Assumes: Included by bare name from the package and the modules
// Notes: Numbers only, no logic
`ifndef SWA_DEFS_SVH
`define SWA_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SWA_WORD_W 16
`define SWA_DWORD_W 32
`define SWA_SUM_W 33
`define SWA_INDEX_W 8
`define SWA_BCD_DIGITS 10
`define SWA_BCD_W 40
`define SWA_DEC_ACC_W 36

// ----------------------------------------------------------------
// Function codes of the arithmetic group
// ----------------------------------------------------------------
`define SWA_FC_FIRST 8'h14
`define SWA_FC_LAST 8'h1D

// ----------------------------------------------------------------
// Signed limits, sign-extended to the wide sum
// ----------------------------------------------------------------
`define SWA_MAX16 33'h0_0000_7FFF
`define SWA_MIN16 33'h1_FFFF_8000
`define SWA_MAX32 33'h0_7FFF_FFFF
`define SWA_MIN32 33'h1_8000_0000

// ----------------------------------------------------------------
// Decimal conversion
// ----------------------------------------------------------------
`define SWA_DEC_BASE 36'h0_0000_000A
`define SWA_DIGIT_MAX 4'h9
`define SWA_INDEX_STEP 8'h01

`endif

/* File: swa_pkg.sv */
// Purpose: Types shared by the signed word adder modules
// Assumes: swa_defs.svh gives the widths
// Notes: Types only
`include "swa_defs.svh"

package swa_pkg;

  // ----------------------------------------------------------------
  // Function codes 20 to 29
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    SWA_ADD_OP = 8'b0001_0100,
    SWA_SUB_OP = 8'b0001_0101,
    SWA_MULTIPLY_OP = 8'b0001_0110,
    SWA_DIV_OP = 8'b0001_0111,
    SWA_INC_OP = 8'b0001_1000,
    SWA_DECREMENT_OP = 8'b0001_1001,
    SWA_WAND_OP = 8'b0001_1010,
    SWA_WOR_OP = 8'b0001_1011,
    SWA_WORD_XOR_OP = 8'b0001_1100,
    SWA_NEGATE_OP = 8'b0001_1101
  } swa_fc_t;

  // ----------------------------------------------------------------
  // Operand, command and flag carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic isImm;
    logic [`SWA_INDEX_W-1:0] index;
    logic immNeg;
    logic [`SWA_BCD_W-1:0] immBcd;
  } swa_src_t;

  typedef struct packed {
    logic [7:0] functionCode;
    logic doubleWord;
    logic pulseMode;
    swa_src_t firstSource;
    swa_src_t secondSource;
    logic [`SWA_INDEX_W-1:0] dstIndex;
  } swa_cmd_t;

  typedef struct packed {
    logic zero;
    logic borrow;
    logic carry;
  } swa_flags_t;

endpackage

/* File: swa_add_core.sv */
// Purpose: Signed add of two operands with zero, borrow and carry
// Assumes: Operands arrive sign-extended to the double width
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "swa_defs.svh"

module swa_add_core (
  input wire logic [`SWA_DWORD_W-1:0] opA,
  input wire logic [`SWA_DWORD_W-1:0] opB,
  input wire logic doubleWord,
  output logic [`SWA_DWORD_W-1:0] result,
  output swa_pkg::swa_flags_t flags
);
  import swa_pkg::*;

  logic [`SWA_SUM_W-1:0] trueSum;
  logic [`SWA_DWORD_W-1:0] stored;

  // Wide sum keeps the true value so limits compare exactly
  assign trueSum = {opA[`SWA_DWORD_W-1], opA} + {opB[`SWA_DWORD_W-1], opB}; // see RL3

  always_comb begin
    if (doubleWord) begin
      stored = trueSum[`SWA_DWORD_W-1:0]; // see RL4
      flags.carry = $signed(trueSum) > $signed(`SWA_MAX32); // see RL8
      flags.borrow = $signed(trueSum) < $signed(`SWA_MIN32); // see RL7
    end else begin
      stored = {{`SWA_WORD_W{trueSum[`SWA_WORD_W-1]}}, trueSum[`SWA_WORD_W-1:0]}; // see RL2
      flags.carry = $signed(trueSum) > $signed(`SWA_MAX16); // see RL8
      flags.borrow = $signed(trueSum) < $signed(`SWA_MIN16); // see RL7
    end
    flags.zero = (stored == '0); // see RL6
  end

  assign result = stored;

endmodule
`default_nettype wire

/* File: swa_word_adder.sv */
// Purpose: Add unit of the instruction executor with word storage
// Assumes: Sequencer is on clk and gives one scanStrobe per scan
// Notes: Only function code 20 executes; 21 to 29 are decoded and
// reported as not built.
//
// Notes on behaviour
// RL1: Decode codes 20-29; only add executes.
// RL2: Single word: add sources, store sum.
// RL3: Operands signed two's complement, added algebraically.
// RL4: Double word: paired sources, 32-bit sum stored.
// RL5: Decimal immediates converted to binary before adding.
// RL6: Zero flag set exactly when result zero.
// RL7: Borrow set when sum below negative limit.
// RL8: Carry set when sum above positive limit.
// RL9: Sequencer gives low index; next index upper.
// RL10: Destination may alias source; re-adds each scan.
// RL11: Continuous every enabled scan; pulse on rise.
// RL12: Flags and destination change only on execution.
`timescale 1ns/1ps
`default_nettype none
`include "swa_defs.svh"

module swa_word_adder #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scanStrobe,
  input wire logic enable,
  input wire swa_pkg::swa_cmd_t cmd,
  input wire logic hostWrite,
  input wire logic [`SWA_INDEX_W-1:0] hostIndex,
  input wire logic [`SWA_WORD_W-1:0] hostData,
  input wire logic [`SWA_INDEX_W-1:0] readIndex,
  output logic [`SWA_WORD_W-1:0] readData,
  output logic zero_flag,
  output logic borrow_flag,
  output logic carry_flag,
  output logic addDone,
  output logic opNotBuilt,
  output logic operandError
);
  import swa_pkg::*;

  localparam int IDX_W = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Decimal immediate helpers
  // ----------------------------------------------------------------
  function automatic logic bcd_valid(input logic [`SWA_BCD_W-1:0] bcd);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < `SWA_BCD_DIGITS; i++) begin
      if (bcd[i*4 +: 4] > `SWA_DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Digits are most significant first; out-of-range magnitudes wrap
  function automatic logic [`SWA_DWORD_W-1:0] dec_to_bin(
    input logic [`SWA_BCD_W-1:0] bcd,
    input logic neg
  );
    logic [`SWA_DEC_ACC_W-1:0] acc;
    logic [`SWA_DWORD_W-1:0] mag;
    acc = '0;
    for (int i = `SWA_BCD_DIGITS - 1; i >= 0; i--) begin
      acc = `SWA_DEC_ACC_W'(acc * `SWA_DEC_BASE) + `SWA_DEC_ACC_W'(bcd[i*4 +: 4]);
    end
    mag = acc[`SWA_DWORD_W-1:0];
    return neg ? `SWA_DWORD_W'(-mag) : mag;
  endfunction

  // ----------------------------------------------------------------
  // Word storage
  // ----------------------------------------------------------------
  logic [`SWA_WORD_W-1:0] wordMem [DEPTH];

  function automatic logic [IDX_W-1:0] low_idx(input logic [`SWA_INDEX_W-1:0] idx);
    return idx[IDX_W-1:0];
  endfunction

  function automatic logic [IDX_W-1:0] high_idx(input logic [`SWA_INDEX_W-1:0] idx);
    logic [`SWA_INDEX_W-1:0] nxt;
    nxt = idx + `SWA_INDEX_STEP;
    return nxt[IDX_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------
  logic [`SWA_DWORD_W-1:0] opA;
  logic [`SWA_DWORD_W-1:0] opB;
  logic [`SWA_DWORD_W-1:0] memA;
  logic [`SWA_DWORD_W-1:0] memB;
  logic [`SWA_DWORD_W-1:0] immA;
  logic [`SWA_DWORD_W-1:0] immB;
  logic [`SWA_WORD_W-1:0] lowA;
  logic [`SWA_WORD_W-1:0] lowB;
  logic immBad;

  always_comb begin
    lowA = wordMem[low_idx(cmd.firstSource.index)];
    lowB = wordMem[low_idx(cmd.secondSource.index)];
    // Upper half comes from the next index; even indexes avoid overlap
    if (cmd.doubleWord) begin
      memA = {wordMem[high_idx(cmd.firstSource.index)], lowA}; // see RL9
      memB = {wordMem[high_idx(cmd.secondSource.index)], lowB}; // see RL9
    end else begin
      memA = {{`SWA_WORD_W{lowA[`SWA_WORD_W-1]}}, lowA}; // see RL3
      memB = {{`SWA_WORD_W{lowB[`SWA_WORD_W-1]}}, lowB}; // see RL3
    end
  end

  always_comb begin
    immA = dec_to_bin(cmd.firstSource.immBcd, cmd.firstSource.immNeg); // see RL5
    immB = dec_to_bin(cmd.secondSource.immBcd, cmd.secondSource.immNeg); // see RL5
    // A single-word immediate keeps its low word, sign-extended
    if (!cmd.doubleWord) begin
      immA = {{`SWA_WORD_W{immA[`SWA_WORD_W-1]}}, immA[`SWA_WORD_W-1:0]};
      immB = {{`SWA_WORD_W{immB[`SWA_WORD_W-1]}}, immB[`SWA_WORD_W-1:0]};
    end
    opA = cmd.firstSource.isImm ? immA : memA;
    opB = cmd.secondSource.isImm ? immB : memB;
    immBad = (cmd.firstSource.isImm && !bcd_valid(cmd.firstSource.immBcd)) ||
             (cmd.secondSource.isImm && !bcd_valid(cmd.secondSource.immBcd));
  end

  // ----------------------------------------------------------------
  // Adder
  // ----------------------------------------------------------------
  logic [`SWA_DWORD_W-1:0] sum;
  swa_flags_t newFlags;

  swa_add_core u_core (
    .opA(opA),
    .opB(opB),
    .doubleWord(cmd.doubleWord),
    .result(sum),
    .flags(newFlags)
  );

  // ----------------------------------------------------------------
  // Decode and execution condition
  // ----------------------------------------------------------------
  logic inGroup;
  logic isAdd;
  logic trigger;
  logic execute;
  logic enablePrev_reg;

  always_comb begin
    inGroup = (cmd.functionCode >= `SWA_FC_FIRST) && (cmd.functionCode <= `SWA_FC_LAST); // see RL1
    isAdd = (cmd.functionCode == SWA_ADD_OP); // see RL1
    // Pulse mode needs a low-to-high enable seen across two scans
    trigger = cmd.pulseMode ? (enable && !enablePrev_reg) : enable; // see RL11
    execute = scanStrobe && trigger && isAdd && !immBad;
  end

  // Enable history is kept per scan, not per clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enablePrev_reg <= 1'b0;
    end else if (scanStrobe) begin
      enablePrev_reg <= enable; // see RL11
    end
  end

  // ----------------------------------------------------------------
  // Storage writes
  // ----------------------------------------------------------------
  // An execution wins over a host write in the same cycle; aliasing a
  // source as destination re-adds on every enabled continuous scan.
  always_ff @(posedge clk) begin
    if (execute) begin
      wordMem[low_idx(cmd.dstIndex)] <= sum[`SWA_WORD_W-1:0]; // see RL2, RL10
      if (cmd.doubleWord) begin
        wordMem[high_idx(cmd.dstIndex)] <= sum[`SWA_DWORD_W-1:`SWA_WORD_W]; // see RL4
      end
    end else if (hostWrite) begin
      wordMem[low_idx(hostIndex)] <= hostData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readData <= '0;
    end else begin
      readData <= wordMem[low_idx(readIndex)];
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_flag <= 1'b0;
      borrow_flag <= 1'b0;
      carry_flag <= 1'b0;
    end else if (execute) begin
      zero_flag <= newFlags.zero; // see RL6, RL12
      borrow_flag <= newFlags.borrow; // see RL7, RL12
      carry_flag <= newFlags.carry; // see RL8, RL12
    end
  end

  // ----------------------------------------------------------------
  // Status pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addDone <= 1'b0;
      opNotBuilt <= 1'b0;
      operandError <= 1'b0;
    end else begin
      addDone <= execute;
      opNotBuilt <= scanStrobe && trigger && inGroup && !isAdd; // see RL1
      operandError <= scanStrobe && trigger && isAdd && immBad;
    end
  end

endmodule
`default_nettype wire

/* File: swa_word_adder_asserts.sv */
// Purpose: Concurrent checks on the adder's scan answers and flags
// Assumes: Bound into swa_word_adder, sees only its ports
// Notes: The scan trigger is rebuilt from the scan inputs and a local history
`timescale 1ns/1ps
`default_nettype none
module swa_word_adder_asserts #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scanStrobe,
  input wire logic enable,
  input wire swa_pkg::swa_cmd_t cmd,
  input wire logic zero_flag,
  input wire logic borrow_flag,
  input wire logic carry_flag,
  input wire logic addDone,
  input wire logic opNotBuilt,
  input wire logic operandError
);
  import swa_pkg::*;
  logic prevEn_reg;
  logic [7:0] fc;
  assign fc = cmd.functionCode;
  // History moves only on scans, else pulse mode would see stale edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prevEn_reg <= 1'b0;
    end else if (scanStrobe) begin
      prevEn_reg <= enable;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_fire;
    scanStrobe && enable && (!cmd.pulseMode || !prevEn_reg);
  endsequence
  sequence s_flagMove;
    !$stable({zero_flag, borrow_flag, carry_flag});
  endsequence
  a_add_answers: assert property (s_fire ##0 fc == 8'h14 |=> addDone || operandError)
    else $error("add scan gave no answer");
  a_code_refused: assert property (s_fire ##0 fc > 8'h14 && fc < 8'h1E |=> opNotBuilt && !addDone)
    else $error("unbuilt code not reported");
  a_other_quiet: assert property (scanStrobe && (fc < 8'h14 || fc > 8'h1D) |=> !addDone && !opNotBuilt)
    else $error("code outside group answered");
  a_pulse_once: assert property (scanStrobe && cmd.pulseMode && prevEn_reg |=> !addDone)
    else $error("pulse scan executed without rising enable");
  a_idle_quiet: assert property (!scanStrobe || !enable |=> !addDone && !opNotBuilt && !operandError)
    else $error("answer without enabled scan");
  a_flags_gated: assert property (s_flagMove |-> addDone)
    else $error("flags moved without an add");
  a_flag_excl: assert property (addDone |-> !(borrow_flag && carry_flag))
    else $error("borrow and carry both set");
  a_zero_wrap: assert property (addDone && carry_flag |-> !zero_flag)
    else $error("zero set on overflowed sum");
endmodule
bind swa_word_adder swa_word_adder_asserts #(.DEPTH(DEPTH)) i_chk (
  .clk(clk),
  .reset_n(reset_n),
  .scanStrobe(scanStrobe),
  .enable(enable),
  .cmd(cmd),
  .zero_flag(zero_flag),
  .borrow_flag(borrow_flag),
  .carry_flag(carry_flag),
  .addDone(addDone),
  .opNotBuilt(opNotBuilt),
  .operandError(operandError)
);
`default_nettype wire

/* File: swa_seq_model.sv */
// Purpose: Instruction sequencer model that feeds scans to the adder
// Assumes: One scan per call, held over one sampling edge
// Notes: Command lines are scrambled between scans
`timescale 1ns/1ps
`default_nettype none
module swa_seq_model (
  input wire logic clk,
  output logic scanStrobe,
  output logic enable,
  output swa_pkg::swa_cmd_t cmd
);
  import swa_pkg::*;
  initial begin
    scanStrobe = 1'b0;
    enable = 1'b0;
    cmd = '0;
  end
  task automatic scan(input logic en, input logic [7:0] fc, input logic [1:0] md,
      input swa_src_t a, input swa_src_t b, input logic [7:0] d);
    @(posedge clk);
    #1;
    scanStrobe = 1'b1;
    enable = en;
    cmd = '{fc, md[1], md[0], a, b, d};
    @(posedge clk);
    #1;
    scanStrobe = 1'b0;
    // Released lines must not keep looking like the last command
    cmd = ~cmd;
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: Scan-level tests of the signed word adder
// Assumes: Sequencer model drives scans, bench drives the host port
// Notes: Expected sums worked out by hand in two's complement
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import swa_pkg::*;
  localparam logic ON = 1'b1;
  localparam logic OFF = 1'b0;
  localparam logic [6:0] PE = 7'b1011011;
  localparam logic [6:0] PD = 7'b1001011;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hostWrite = 1'b0;
  logic [7:0] hostIndex = 8'h00;
  logic [15:0] hostData = 16'h0000;
  logic [7:0] readIndex = 8'h00;
  logic [15:0] readData;
  logic zero_flag, borrow_flag, carry_flag, addDone, opNotBuilt, operandError;
  logic scanStrobe;
  logic enable;
  swa_cmd_t cmd;
  int err_total = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  swa_seq_model i_seq (.clk(clk), .scanStrobe(scanStrobe), .enable(enable), .cmd(cmd));
  swa_word_adder #(.DEPTH(256)) i_dut (.clk(clk), .reset_n(reset_n), .scanStrobe(scanStrobe),
    .enable(enable), .cmd(cmd), .hostWrite(hostWrite), .hostIndex(hostIndex),
    .hostData(hostData), .readIndex(readIndex), .readData(readData), .zero_flag(zero_flag),
    .borrow_flag(borrow_flag), .carry_flag(carry_flag), .addDone(addDone),
    .opNotBuilt(opNotBuilt), .operandError(operandError));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  function automatic swa_src_t w(input int i);
    w = '{1'b0, i[7:0], 1'b0, 40'h0};
  endfunction
  function automatic swa_src_t k(input logic n, input logic [39:0] v);
    k = '{1'b1, 8'h00, n, v};
  endfunction
  task automatic wr(input int i, input logic [15:0] d);
    @(posedge clk);
    #1;
    hostWrite = 1'b1;
    hostIndex = i[7:0];
    hostData = d;
    @(posedge clk);
    #1;
    hostWrite = 1'b0;
  endtask
  task automatic rd(input int i, input logic [15:0] e);
    @(posedge clk);
    #1;
    readIndex = i[7:0];
    @(posedge clk);
    #1;
    `CHK(readData, e)
  endtask
  task automatic go(input logic en, input int fc, input logic [1:0] md, input swa_src_t a,
      input swa_src_t b, input int d, input logic [5:0] e);
    i_seq.scan(en, fc[7:0], md, a, b, d[7:0]);
    `CHK({addDone, opNotBuilt, operandError, zero_flag, borrow_flag, carry_flag}, e)
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Tests need about a hundred cycles; this span is far beyond that
  initial begin
    #2_000_000;
    err_total++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    wr(0, 16'h0005);
    wr(1, 16'hFFF8);
    go(ON, 20, 2'b00, w(0), w(1), 2, 6'h20);
    rd(2, 16'hFFFD);
    wr(0, 16'h7FFF);
    go(ON, 20, 2'b00, w(0), k(OFF, 40'h1), 2, 6'h21);
    rd(2, 16'h8000);
    wr(0, 16'h8000);
    go(ON, 20, 2'b00, w(0), k(ON, 40'h1), 2, 6'h22);
    rd(2, 16'h7FFF);
    go(ON, 20, 2'b00, w(0), w(0), 2, 6'h26);
    go(OFF, 20, 2'b00, w(0), k(OFF, 40'h1), 2, 6'h06);
    rd(2, 16'h0000);
    $display("test single words done");
    for (int c = 19; c <= 29; c++) begin
      go(ON, c, 2'b00, w(0), w(1), 3, {c == 20, c > 20, 1'b0, c < 20, 2'b10});
    end
    go(ON, 20, 2'b00, w(0), k(OFF, 40'h1A), 3, 6'h0A);
    rd(3, 16'h7FF8);
    $display("test function codes done");
    wr(4, 16'h157C);
    wr(5, 16'h0000);
    wr(6, 16'hDEA4);
    wr(7, 16'hFFFF);
    go(ON, 20, 2'b10, w(4), w(6), 8, 6'h20);
    rd(8, 16'hF420);
    rd(9, 16'hFFFF);
    go(ON, 20, 2'b10, k(OFF, 40'h21_4748_3647), k(OFF, 40'h1), 8, 6'h21);
    rd(9, 16'h8000);
    go(ON, 20, 2'b10, k(ON, 40'h21_4748_3648), k(ON, 40'h1), 8, 6'h22);
    rd(9, 16'h7FFF);
    $display("test double words done");
    wr(0, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      go(PE[i], 20, {1'b0, i > 1}, w(0), k(OFF, 40'h25), 0, {PD[i], 5'h00});
    end
    rd(0, 16'h0064);
    go(ON, 20, 2'b00, w(0), k(ON, 40'h100), 1, 6'h24);
    // Reset in mid-run clears flags and the enable history
    @(posedge clk);
    #1;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK({addDone, opNotBuilt, operandError, zero_flag, borrow_flag, carry_flag, readData}, 22'h00_0000)
    reset_n = 1'b1;
    go(ON, 20, 2'b01, w(0), k(OFF, 40'h1), 1, 6'h20);
    rd(1, 16'h0065);
    $display("test scan modes done");
    summarize();
  end
endmodule
`default_nettype wire
